// file: logic/isx_pkg.sv
// Purpose: shared constants for the indexed/stack instruction executor
// Assumes: 16-bit instruction words, 12-bit data addresses and pointers
// Notes:   encodings are matched on the upper bits of each word
package isx_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam int PC_W   = 21;
   // ****************************************
   // encodings
   // ****************************************
   localparam logic [8:0] MOVE_W1_PREFIX = 9'h1D7;   // 1110 1011 1
   localparam logic [3:0] MOVE_W2_PREFIX = 4'hF;
   localparam logic [7:0] PUSH_PREFIX    = 8'hFA;
   localparam logic [7:0] PSUB_PREFIX    = 8'hE9;
   localparam logic [1:0] SEL_RETURN     = 2'h3;
   // ****************************************
   // special addresses
   // ****************************************
   localparam logic [ADDR_W-1:0] INDF0_ADDR = 12'hFEF;
   localparam logic [ADDR_W-1:0] INDF1_ADDR = 12'hFE7;
   localparam logic [ADDR_W-1:0] INDF2_ADDR = 12'hFDF;
   localparam logic [ADDR_W-1:0] PC_LOW_ADDR     = 12'hFF9;
   localparam logic [ADDR_W-1:0] STACK_LOW_ADDR  = 12'hFFD;
   localparam logic [ADDR_W-1:0] STACK_HIGH_ADDR = 12'hFFE;
   localparam logic [ADDR_W-1:0] STACK_UP_ADDR   = 12'hFFF;
   localparam logic [DATA_W-1:0] ZERO_DATA  = 8'h00;
   localparam logic [ADDR_W-1:0] PTR_RESET  = 12'h000;
   localparam logic [PC_W-1:0]   PC_RESET   = 21'h000000;
   // ****************************************
   // states
   // ****************************************
   typedef enum logic [1:0] {
      ISX_IDLE     = 2'b00,
      ISX_MOVE_DST = 2'b01,
      ISX_RET_NOP  = 2'b10
   } isx_state_t;
endpackage

// file: logic/isx_addr_check.sv
// Purpose: classify a computed data address
// Assumes: fixed special register locations from the package
// Notes:   instantiated once for source and once for destination
module isx_addr_check (
   input  wire logic [11:0] addr,
   output logic             is_indirect,
   output logic             is_stack_pc
);
   assign is_indirect = (addr == isx_pkg::INDF0_ADDR) || (addr == isx_pkg::INDF1_ADDR) ||
                        (addr == isx_pkg::INDF2_ADDR);
   assign is_stack_pc = (addr == isx_pkg::PC_LOW_ADDR) || (addr == isx_pkg::STACK_LOW_ADDR) ||
                        (addr == isx_pkg::STACK_HIGH_ADDR) || (addr == isx_pkg::STACK_UP_ADDR);
endmodule

// file: logic/isx_exec.sv
// Purpose: decode and execute indexed move, push literal, pointer subtract and subtract-return
// Assumes: one instr_valid per instruction cycle; memory read data is combinational
// Notes:   pointers are held here; flags are never touched by these instructions
module isx_exec (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   output logic             instr_ready,
   output logic [11:0]      mem_addr,
   output logic             mem_rd,
   input  wire logic [7:0]  mem_rdata,
   output logic             mem_we,
   output logic [7:0]       mem_wdata,
   output logic [11:0]      pointer_zero,
   output logic [11:0]      pointer_one,
   output logic [11:0]      pointer_two,
   input  wire logic [20:0] return_stack_top,
   output logic             pc_load,
   output logic [20:0]      pc_value,
   output logic             stack_pop,
   output logic             flags_hold
);
   // ****************************************
   // state
   // ****************************************
   isx_pkg::isx_state_t state_q, state_d;
   logic [11:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d, ptr2_q, ptr2_d;
   logic [7:0]  data_q, data_d;
   logic [11:0] addr_q, addr_d;
   logic        we_q, we_d, pc_ld_q, pc_ld_d, pop_q, pop_d;
   logic [20:0] pcv_q, pcv_d;
   logic [11:0] src_addr, dst_addr;
   logic        src_ind, dst_ind, dst_bad, take;
   logic [7:0]  op_hi;
   logic [5:0]  lit6;
   logic [1:0]  sel;
   logic        is_move, is_push, is_psub;

   assign op_hi   = instr_word[15:8];
   assign lit6    = instr_word[5:0];
   assign sel     = instr_word[7:6];
   assign is_move = instr_word[15:7] == isx_pkg::MOVE_W1_PREFIX;
   assign is_push = op_hi == isx_pkg::PUSH_PREFIX;
   assign is_psub = op_hi == isx_pkg::PSUB_PREFIX;

   // 12-bit add wraps modulo the data space
   assign src_addr = ptr2_q + {5'h00, instr_word[6:0]};
   assign dst_addr = ptr2_q + {5'h00, instr_word[6:0]};

   isx_addr_check u_src (
      .addr        (src_addr),
      .is_indirect (src_ind),
      .is_stack_pc ()
   );
   isx_addr_check u_dst (
      .addr        (dst_addr),
      .is_indirect (dst_ind),
      .is_stack_pc (dst_bad)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      state_d = state_q;
      ptr0_d  = ptr0_q;
      ptr1_d  = ptr1_q;
      ptr2_d  = ptr2_q;
      data_d  = data_q;
      addr_d  = addr_q;
      we_d    = 1'b0;
      pc_ld_d = 1'b0;
      pop_d   = 1'b0;
      pcv_d   = pcv_q;
      case (state_q)
         isx_pkg::ISX_IDLE: begin
            if (take) begin
               if (is_move) begin
                  // source read now, held until the second word arrives
                  data_d  = src_ind ? isx_pkg::ZERO_DATA : mem_rdata;
                  state_d = isx_pkg::ISX_MOVE_DST;
               end else if (is_push) begin
                  addr_d = ptr2_q;
                  data_d = instr_word[7:0];
                  we_d   = 1'b1;
                  ptr2_d = ptr2_q - 12'h001;
               end else if (is_psub) begin
                  case (sel)
                     2'h0: ptr0_d = ptr0_q - {6'h00, lit6};
                     2'h1: ptr1_d = ptr1_q - {6'h00, lit6};
                     2'h2: ptr2_d = ptr2_q - {6'h00, lit6};
                     default: begin
                        ptr2_d  = ptr2_q - {6'h00, lit6};
                        pcv_d   = return_stack_top;
                        pc_ld_d = 1'b1;
                        pop_d   = 1'b1;
                        state_d = isx_pkg::ISX_RET_NOP;
                     end
                  endcase
               end
            end
         end
         isx_pkg::ISX_MOVE_DST: begin
            if (instr_valid) begin
               state_d = isx_pkg::ISX_IDLE;
               // a bad second word or forbidden target degrades to a no-op
               if (instr_word[15:12] == isx_pkg::MOVE_W2_PREFIX && !dst_ind && !dst_bad) begin
                  addr_d = dst_addr;
                  we_d   = 1'b1;
               end
            end
         end
         isx_pkg::ISX_RET_NOP: begin
            if (instr_valid) begin
               state_d = isx_pkg::ISX_IDLE;
            end
         end
         default: state_d = isx_pkg::ISX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= isx_pkg::ISX_IDLE;
         ptr0_q  <= isx_pkg::PTR_RESET;
         ptr1_q  <= isx_pkg::PTR_RESET;
         ptr2_q  <= isx_pkg::PTR_RESET;
         data_q  <= isx_pkg::ZERO_DATA;
         addr_q  <= isx_pkg::PTR_RESET;
         we_q    <= 1'b0;
         pc_ld_q <= 1'b0;
         pop_q   <= 1'b0;
         pcv_q   <= isx_pkg::PC_RESET;
      end else begin
         state_q <= state_d;
         ptr0_q  <= ptr0_d;
         ptr1_q  <= ptr1_d;
         ptr2_q  <= ptr2_d;
         data_q  <= data_d;
         addr_q  <= addr_d;
         we_q    <= we_d;
         pc_ld_q <= pc_ld_d;
         pop_q   <= pop_d;
         pcv_q   <= pcv_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // source read address is combinational so the read lands in the first cycle
   // a move read cannot share the one memory port with a pending write, so the move waits a cycle
   assign instr_ready  = !((state_q == isx_pkg::ISX_IDLE) && we_q && is_move);
   assign take         = instr_valid && instr_ready;
   assign mem_rd       = (state_q == isx_pkg::ISX_IDLE) && take && is_move && !src_ind;
   assign mem_addr     = mem_rd ? src_addr : addr_q;
   assign mem_we       = we_q;
   assign mem_wdata    = data_q;
   assign pointer_zero = ptr0_q;
   assign pointer_one  = ptr1_q;
   assign pointer_two  = ptr2_q;
   assign pc_load      = pc_ld_q;
   assign pc_value     = pcv_q;
   assign stack_pop    = pop_q;
   assign flags_hold   = 1'b1;

   // ****************************************
   // checks
   // ****************************************
   a_push_decrement: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == isx_pkg::ISX_IDLE && instr_valid && is_push) |=>
         (pointer_two == $past(ptr2_q) - 12'h001) && mem_we && mem_addr == $past(ptr2_q))
      else $error("push did not write and decrement");
   a_ret_two_cycle: assert property (@(posedge clk) disable iff (!rstn)
      pc_load |-> state_q == isx_pkg::ISX_RET_NOP && !mem_we)
      else $error("return not followed by idle cycle");
   a_move_no_ind: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == isx_pkg::ISX_MOVE_DST && instr_valid && dst_ind) |=> !mem_we)
      else $error("write to indirect destination");
   a_move_no_stack: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == isx_pkg::ISX_MOVE_DST && instr_valid && dst_bad) |=> !mem_we)
      else $error("write to pc or stack byte");
   a_src_zero: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == isx_pkg::ISX_IDLE && take && is_move && src_ind) |=> data_q == 8'h00)
      else $error("indirect source not zero");
   a_psub_ptr0: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == isx_pkg::ISX_IDLE && instr_valid && is_psub && sel == 2'h0) |=>
         pointer_zero == $past(ptr0_q) - {6'h00, $past(lit6)})
      else $error("pointer subtract wrong");
   a_ret_sub: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == isx_pkg::ISX_IDLE && instr_valid && is_psub && sel == 2'h3) |=>
         pc_load && pointer_two == $past(ptr2_q) - {6'h00, $past(lit6)})
      else $error("subtract-return wrong");
   a_move_write: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == isx_pkg::ISX_MOVE_DST && instr_valid && !dst_ind && !dst_bad &&
       instr_word[15:12] == 4'hF) |=> mem_we && mem_addr == $past(dst_addr))
      else $error("move destination not written");
   a_no_rd_wr: assert property (@(posedge clk) disable iff (!rstn)
      !(mem_rd && mem_we))
      else $error("read and write share the memory port");
   a_ret_target: assert property (@(posedge clk) disable iff (!rstn)
      pc_load |-> stack_pop && pc_value == $past(return_stack_top))
      else $error("return target not taken from stack top");
endmodule

// file: verif/tb_top.sv
// Purpose: self-checking bench for the indexed/stack instruction executor
// Assumes: words driven on the rising edge; memory read data answered the same cycle
// Notes:   pointer values chain from one scenario to the next, so task order matters
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // signals
   // ****************************************
   logic        clk;
   logic        rstn;
   logic        instr_valid;
   logic [15:0] instr_word;
   logic        instr_ready;
   logic [11:0] mem_addr;
   logic        mem_rd;
   logic [7:0]  mem_rdata;
   logic        mem_we;
   logic [7:0]  mem_wdata;
   logic [11:0] pointer_zero;
   logic [11:0] pointer_one;
   logic [11:0] pointer_two;
   logic [20:0] return_stack_top;
   logic        pc_load;
   logic [20:0] pc_value;
   logic        stack_pop;
   logic        flags_hold;
   int          miscompares;
   int          checks;
   isx_exec dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
      .mem_we(mem_we), .mem_wdata(mem_wdata), .pointer_zero(pointer_zero),
      .pointer_one(pointer_one), .pointer_two(pointer_two), .return_stack_top(return_stack_top),
      .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop), .flags_hold(flags_hold));
   // ****************************************
   // drivers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic step(input logic [15:0] w);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word  <= w;
      #1;
   endtask
   task automatic idle();
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // pointer two starts at 000h, so the decrement must wrap to FFFh
   task automatic t_push();
      step(16'hFA5C);
      `CHK(instr_ready, 1'b1)
      idle();
      `CHK(mem_we, 1'b1)
      `CHK(mem_addr, 12'h000)
      `CHK(mem_wdata, 8'h5C)
      `CHK(pointer_two, 12'hFFF)
   endtask
   task automatic t_psub();
      logic [11:0] exp [3];
      exp = '{12'hFC1, 12'hFC1, 12'hFC0};
      for (int s = 0; s < 3; s++) begin
         step({8'hE9, s[1:0], 6'h3F});
         idle();
      end
      `CHK(pointer_zero, exp[0])
      `CHK(pointer_one, exp[1])
      `CHK(pointer_two, exp[2])
      `CHK(flags_hold, 1'b1)
   endtask
   // pointer two is FC0h here; offsets pick plain, indirect and protected places
   task automatic t_move(input logic [6:0] so, input logic [6:0] dof, input logic [11:0] sa,
                         input logic rd, input logic [11:0] da, input logic we,
                         input logic [7:0] wd);
      mem_rdata <= 8'hA5;
      step({9'h1D7, so});
      `CHK(mem_rd, rd)
      if (rd) begin
         `CHK(mem_addr, sa)
      end
      step({4'hF, 5'h00, dof});
      mem_rdata <= 8'h3C;
      idle();
      `CHK(mem_we, we)
      if (we) begin
         `CHK(mem_addr, da)
         `CHK(mem_wdata, wd)
      end
   endtask
   // the word after the return must be swallowed, not executed as a push
   task automatic t_subret();
      return_stack_top <= 21'h1ABCD;
      step(16'hE9C5);
      step(16'hFA77);
      `CHK(pc_load, 1'b1)
      `CHK(stack_pop, 1'b1)
      `CHK(pc_value, 21'h1ABCD)
      `CHK(pointer_two, 12'hFBB)
      `CHK(pointer_zero, 12'hFC1)
      idle();
      `CHK(mem_we, 1'b0)
      `CHK(pc_load, 1'b0)
      `CHK(pointer_two, 12'hFBB)
   endtask
   // a move word right behind a push must wait for the push write to leave the port
   task automatic t_stall();
      mem_rdata <= 8'h66;
      step(16'hFA11);
      step(16'hEB80);
      `CHK(instr_ready, 1'b0)
      `CHK(mem_we, 1'b1)
      `CHK(mem_addr, 12'hFBB)
      `CHK(mem_wdata, 8'h11)
      step(16'hEB80);
      `CHK(instr_ready, 1'b1)
      `CHK(mem_rd, 1'b1)
      `CHK(mem_addr, 12'hFBA)
      step(16'hF001);
      idle();
      `CHK(mem_we, 1'b1)
      `CHK(mem_addr, 12'hFBB)
      `CHK(mem_wdata, 8'h66)
   endtask
   // ****************************************
   // closing
   // ****************************************
   task automatic summarize();
      if (miscompares == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #5000;
      miscompares++;
      summarize();
   end
   initial begin
      rstn             = 1'b0;
      instr_valid      = 1'b0;
      instr_word       = 16'h0000;
      mem_rdata        = 8'h00;
      return_stack_top = 21'h000000;
      miscompares      = 0;
      checks           = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_push();
      t_psub();
      t_move(7'h10, 7'h7F, 12'hFD0, 1'b1, 12'h03F, 1'b1, 8'hA5);
      t_move(7'h2F, 7'h10, 12'hFEF, 1'b0, 12'hFD0, 1'b1, 8'h00);
      t_move(7'h10, 7'h1F, 12'hFD0, 1'b1, 12'hFDF, 1'b0, 8'h00);
      t_move(7'h10, 7'h39, 12'hFD0, 1'b1, 12'hFF9, 1'b0, 8'h00);
      t_move(7'h10, 7'h3D, 12'hFD0, 1'b1, 12'hFFD, 1'b0, 8'h00);
      t_subret();
      t_stall();
      summarize();
   end
endmodule
